/* hw/eag_pkg.sv */
// Constants and types for the effective address generator.
// Assumes a single core clock and decoder-driven request fields.
package eag_pkg;
  localparam int unsigned EAG_DATA_W = 32;
  localparam int unsigned EAG_NUM_REGS = 8;
  localparam int unsigned EAG_IDX_W = 3;
  localparam logic [2:0] EAG_SP_IDX = 3'h4;
  localparam logic [31:0] EAG_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] EAG_MASK16 = 32'h0000_ffff;
  localparam logic [31:0] EAG_MASK8 = 32'h0000_00ff;
  localparam int unsigned EAG_EXTRA_CLKS = 1;

  // Where an operand lives
  typedef enum logic [1:0] {
    EAG_KIND_NONE = 2'b00,
    EAG_KIND_REG = 2'b01,
    EAG_KIND_IMM = 2'b10,
    EAG_KIND_MEM = 2'b11
  } eag_kind_type;

  // Displacement width carried by the instruction
  typedef enum logic [1:0] {
    EAG_DISP_NONE = 2'b00,
    EAG_DISP_8 = 2'b01,
    EAG_DISP_16 = 2'b10,
    EAG_DISP_32 = 2'b11
  } eag_disp_type;

  typedef enum logic {
    EAG_ST_IDLE = 1'b0,
    EAG_ST_EXTRA = 1'b1
  } eag_state_type;
endpackage

/* hw/eag_top.sv */
// Effective address generator: operand select, offset and linear address.
// Assumes the decoder holds request fields stable in the cycle of
// i_req_valid and waits while o_busy is high.
//
// Functional notes
// - Offset equals base plus scaled index plus displacement, each optional.
// - Index value is scaled by 1, 2, 4 or 8 before the add.
// - Any register may index except the stack pointer register.
// - 32-bit scaled-index forms take an 8- or 32-bit displacement only.
// - Offset adds no cycles, except base plus index costs one more.
// - Linear address is segment base plus effective offset.
// - Direct mode uses an 8, 16 or 32-bit displacement as offset.
// - Register indirect uses the base register alone as offset.
// - Based mode adds displacement to the base register.
// - Register operands are read at 8, 16 or 32 bits width.
// - Immediate operands come from the instruction encoding itself.
// - Instructions carry zero to three operands; three-operand forms need a register destination and an immediate third.
// - Two-operand pairings: reg/mem/imm to reg, reg/imm to memory.
// - 32-bit code uses 8/32-bit operands, 16-bit code 8/16-bit.
// - Prefixes replace the default operand length per instruction.
// - Default size is 16 bits when D bit is 0 or real mode.
// - Operand and address prefixes each override the D bit once.
`timescale 1ns/1ps
module eag_top
  import eag_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // General register write-back
  input wire logic i_wr_en,
  input wire logic [2:0] i_wr_idx,
  input wire logic [31:0] i_wr_data,
  // Decoded request
  input wire logic i_req_valid,
  input wire logic [1:0] i_op_count,
  input wire eag_kind_type i_dst_kind,
  input wire eag_kind_type i_src_kind,
  input wire eag_kind_type i_third_kind,
  input wire logic [2:0] i_reg_sel,
  input wire logic i_reg_byte,
  input wire logic [31:0] i_imm,
  input wire logic i_base_en,
  input wire logic [2:0] i_base_sel,
  input wire logic i_index_en,
  input wire logic [2:0] i_index_sel,
  input wire logic [1:0] i_scale_sel,
  input wire eag_disp_type i_disp_size,
  input wire logic [31:0] i_disp,
  input wire logic [31:0] i_seg_base,
  // Size control
  input wire logic i_code_d_bit,
  input wire logic i_real_mode,
  input wire logic i_opsize_pfx,
  input wire logic i_addrsize_pfx,
  // Results
  output logic o_busy,
  output logic o_done,
  output logic [31:0] o_offset,
  output logic [31:0] o_linear_addr,
  output logic [31:0] o_operand,
  output logic o_op32,
  output logic o_addr32,
  output logic o_mem_used,
  output logic o_illegal
);

  // General register file, one flop word per entry
  logic [31:0] gpr_q [EAG_NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < EAG_NUM_REGS; g++) begin : g_gpr
      logic [31:0] word_d;
      always_comb begin
        word_d = gpr_q[g];
        if (i_wr_en && (i_wr_idx == 3'(g))) begin
          word_d = i_wr_data;
        end
      end
      always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          gpr_q[g] <= EAG_RST_WORD;
        end else begin
          gpr_q[g] <= word_d;
        end
      end
    end
  endgenerate

  // Truncate an offset to the active address width
  function automatic logic [31:0] cut_addr(input logic [31:0] a,
                                           input logic wide);
    cut_addr = wide ? a : (a & EAG_MASK16);
  endfunction

  // Request decode
  eag_state_type state_q, state_d;
  logic take;
  logic dflt32;
  logic op32_c;
  logic addr32_c;
  logic index_ok;
  logic both_c;
  logic [31:0] disp_ext;
  logic [31:0] base_val;
  logic [31:0] scaled;
  logic [31:0] partial;
  logic [31:0] oper_c;
  logic mem_c;
  logic bad_c;

  assign take = i_req_valid && (state_q == EAG_ST_IDLE);

  // Default width follows the D bit; real mode forces 16 bits
  assign dflt32 = i_code_d_bit && !i_real_mode;
  assign op32_c = dflt32 ^ i_opsize_pfx;
  assign addr32_c = dflt32 ^ i_addrsize_pfx;

  // Stack pointer can never act as index; it is dropped and flagged
  assign index_ok = i_index_en && (i_index_sel != EAG_SP_IDX);
  assign both_c = i_base_en && index_ok;

  // Operand components
  always_comb begin
    unique case (i_disp_size)
      EAG_DISP_NONE: disp_ext = EAG_RST_WORD;
      EAG_DISP_8: disp_ext = {{24{i_disp[7]}}, i_disp[7:0]};
      EAG_DISP_16: disp_ext = {{16{i_disp[15]}}, i_disp[15:0]};
      EAG_DISP_32: disp_ext = i_disp;
    endcase
    base_val = i_base_en ? gpr_q[i_base_sel] : EAG_RST_WORD;
    scaled = index_ok ? (gpr_q[i_index_sel] << i_scale_sel)
                      : EAG_RST_WORD;
    partial = base_val + scaled;
  end

  // Register or immediate operand at its width
  always_comb begin
    oper_c = EAG_RST_WORD;
    if (i_src_kind == EAG_KIND_REG) begin
      oper_c = gpr_q[i_reg_sel];
    end else if (i_src_kind == EAG_KIND_IMM) begin
      oper_c = i_imm;
    end
    if (i_reg_byte) begin
      oper_c = oper_c & EAG_MASK8;
    end else if (!op32_c) begin
      oper_c = oper_c & EAG_MASK16;
    end
  end

  // Operand count and pairing legality
  always_comb begin
    mem_c = (i_dst_kind == EAG_KIND_MEM) || (i_src_kind == EAG_KIND_MEM);
    bad_c = i_index_en && !index_ok;
    // 16-bit displacement does not exist in 32-bit scaled forms
    if (index_ok && addr32_c && (i_disp_size == EAG_DISP_16)) begin
      bad_c = 1'b1;
    end
    unique case (i_op_count)
      2'd0: bad_c = bad_c || mem_c;
      2'd1: bad_c = bad_c || (i_dst_kind == EAG_KIND_NONE);
      2'd2: begin
        if (i_dst_kind == EAG_KIND_REG) begin
          bad_c = bad_c || (i_src_kind == EAG_KIND_NONE);
        end else if (i_dst_kind == EAG_KIND_MEM) begin
          bad_c = bad_c || (i_src_kind == EAG_KIND_NONE)
                  || (i_src_kind == EAG_KIND_MEM);
        end else begin
          bad_c = 1'b1;
        end
      end
      2'd3: bad_c = bad_c || (i_dst_kind != EAG_KIND_REG)
                    || (i_third_kind != EAG_KIND_IMM);
    endcase
  end

  // Result state
  logic busy_d, done_d, op32_d, addr32_d, mem_d, bad_d;
  logic [31:0] off_d, lin_d, oper_d, part_d, disp_d, seg_d;
  logic done_q, op32_q, addr32_q, mem_q, bad_q, busy_q;
  logic [31:0] off_q, lin_q, oper_q, part_q, disp_q, seg_q;

  // Fast path finishes in one edge; base plus index waits one more
  always_comb begin
    state_d = state_q;
    done_d = 1'b0;
    op32_d = op32_q;
    addr32_d = addr32_q;
    mem_d = mem_q;
    bad_d = bad_q;
    off_d = off_q;
    lin_d = lin_q;
    oper_d = oper_q;
    part_d = part_q;
    disp_d = disp_q;
    seg_d = seg_q;
    unique case (state_q)
      EAG_ST_IDLE: begin
        if (take) begin
          op32_d = op32_c;
          addr32_d = addr32_c;
          mem_d = mem_c;
          bad_d = bad_c;
          oper_d = oper_c;
          seg_d = i_seg_base;
          part_d = partial;
          disp_d = disp_ext;
          if (both_c) begin
            state_d = EAG_ST_EXTRA;
          end else begin
            done_d = 1'b1;
            off_d = cut_addr(partial + disp_ext, addr32_c);
            lin_d = i_seg_base + cut_addr(partial + disp_ext,
                                          addr32_c);
          end
        end
      end
      EAG_ST_EXTRA: begin
        state_d = EAG_ST_IDLE;
        done_d = 1'b1;
        off_d = cut_addr(part_q + disp_q, addr32_q);
        lin_d = seg_q + cut_addr(part_q + disp_q, addr32_q);
      end
    endcase
    busy_d = (state_d == EAG_ST_EXTRA);
  end

  // Result registers
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= EAG_ST_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      op32_q <= 1'b0;
      addr32_q <= 1'b0;
      mem_q <= 1'b0;
      bad_q <= 1'b0;
      off_q <= EAG_RST_WORD;
      lin_q <= EAG_RST_WORD;
      oper_q <= EAG_RST_WORD;
      part_q <= EAG_RST_WORD;
      disp_q <= EAG_RST_WORD;
      seg_q <= EAG_RST_WORD;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
      done_q <= done_d;
      op32_q <= op32_d;
      addr32_q <= addr32_d;
      mem_q <= mem_d;
      bad_q <= bad_d;
      off_q <= off_d;
      lin_q <= lin_d;
      oper_q <= oper_d;
      part_q <= part_d;
      disp_q <= disp_d;
      seg_q <= seg_d;
    end
  end

  // Outputs straight from flops
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_offset = off_q;
  assign o_linear_addr = lin_q;
  assign o_operand = oper_q;
  assign o_op32 = op32_q;
  assign o_addr32 = addr32_q;
  assign o_mem_used = mem_q;
  assign o_illegal = bad_q;

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  sequence seq_slow_take;
    take && both_c;
  endsequence

  sequence seq_slow_finish;
    o_busy && !o_done ##1 !o_busy && o_done;
  endsequence

  AST_SLOW_PATH: assert property (
    seq_slow_take |=> seq_slow_finish)
    else $error("base plus index did not take one extra clock");

  AST_FAST_PATH: assert property (
    take && !both_c |=> o_done && !o_busy)
    else $error("single component offset was delayed");

  AST_LINEAR: assert property (
    o_done |-> o_linear_addr == seg_q + o_offset)
    else $error("linear address is not segment base plus offset");

  AST_TRUNC16: assert property (
    o_done && !o_addr32 |-> o_offset[31:16] == 16'h0000)
    else $error("16-bit offset kept upper bits");

  AST_SP_INDEX: assert property (
    take && i_index_en && i_index_sel == EAG_SP_IDX |=> o_illegal)
    else $error("stack pointer accepted as index");

  AST_DIRECT: assert property (
    take && !i_base_en && !i_index_en |=>
      o_offset == cut_addr($past(disp_ext), $past(addr32_c)))
    else $error("direct offset differs from displacement");

  AST_REG_IND: assert property (
    take && i_base_en && !i_index_en && i_disp_size == EAG_DISP_NONE
    |=> o_offset == cut_addr($past(base_val), $past(addr32_c)))
    else $error("register indirect offset differs from base");

  AST_OPSIZE: assert property (
    take |=> o_op32 == ($past(dflt32) ^ $past(i_opsize_pfx)))
    else $error("operand size ignores default or prefix");

  AST_BYTE_OPER: assert property (
    take && i_reg_byte |=> o_operand[31:8] == 24'h00_0000)
    else $error("byte operand wider than 8 bits");

  AST_PAIRING: assert property (
    take && i_op_count == 2'd2 && i_dst_kind == EAG_KIND_MEM
    && i_src_kind == EAG_KIND_MEM |=> o_illegal)
    else $error("memory to memory pairing accepted");

endmodule

/* test/eag_seg_model.sv */
// Model of the paging path that consumes linear addresses.
// Assumes one result per o_done pulse on the core clock.
`timescale 1ns/1ps
module eag_seg_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Result from the generator
  input wire logic i_done,
  input wire logic [31:0] i_linear_addr,
  // Captured result
  output logic [31:0] o_last_addr,
  output logic [15:0] o_count
);
  // Take the address only on the pulse; it stays held until the next result
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_last_addr <= 32'h0000_0000;
      o_count <= 16'h0000;
    end else if (i_done) begin
      o_last_addr <= i_linear_addr;
      o_count <= o_count + 16'h0001;
    end
  end
endmodule

/* test/tb.sv */
// Self-checking bench for the effective address generator.
// Assumes inputs change at falling edges and a 100 MHz core clock.
`timescale 1ns/1ps
module tb;
  import eag_pkg::*;
  logic mclk, arst_n, wr_en, req_valid, reg_byte, base_en, index_en;
  logic d_bit, real_m, opfx, afx;
  logic [2:0] wr_idx, reg_sel, base_sel, index_sel;
  logic [1:0] scale_sel, op_count;
  logic [31:0] wr_data, imm, disp, seg_base, last_addr;
  logic [15:0] seen;
  eag_kind_type src_kind, dst_kind, third_kind;
  eag_disp_type disp_size;
  logic o_busy, o_done, o_op32, o_addr32, o_mem_used, o_illegal;
  logic [31:0] o_offset, o_linear_addr, o_operand;
  logic [31:0] regs [8];
  int bad_count = 0;
  int tests_run = 0;
  int reqs = 0;
  int seed = 29;

  // Operand count and kinds default to a legal memory form
  eag_top eag_top_i (.i_mclk(mclk), .i_arst_n(arst_n), .i_wr_en(wr_en),
    .i_wr_idx(wr_idx), .i_wr_data(wr_data), .i_req_valid(req_valid),
    .i_op_count(op_count), .i_dst_kind(dst_kind), .i_src_kind(src_kind),
    .i_third_kind(third_kind), .i_reg_sel(reg_sel),
    .i_reg_byte(reg_byte), .i_imm(imm), .i_base_en(base_en),
    .i_base_sel(base_sel), .i_index_en(index_en),
    .i_index_sel(index_sel), .i_scale_sel(scale_sel),
    .i_disp_size(disp_size), .i_disp(disp), .i_seg_base(seg_base),
    .i_code_d_bit(d_bit), .i_real_mode(real_m), .i_opsize_pfx(opfx),
    .i_addrsize_pfx(afx), .o_busy(o_busy), .o_done(o_done),
    .o_offset(o_offset), .o_linear_addr(o_linear_addr),
    .o_operand(o_operand), .o_op32(o_op32), .o_addr32(o_addr32),
    .o_mem_used(o_mem_used), .o_illegal(o_illegal));

  eag_seg_model eag_seg_model_i (.i_mclk(mclk), .i_arst_n(arst_n),
    .i_done(o_done), .i_linear_addr(o_linear_addr),
    .o_last_addr(last_addr), .o_count(seen));

  // Core clock, 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // Write one register; the idle cycle keeps back-to-back writes apart
  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    wr_en = 1'b1;
    wr_idx = i;
    wr_data = d;
    @(negedge mclk);
    wr_en = 1'b0;
    regs[i] = d;
    @(negedge mclk);
  endtask

  // Legality of operand count and placement
  function automatic logic pair_bad(input logic [1:0] c,
    input eag_kind_type d, input eag_kind_type s, input eag_kind_type t);
    case (c)
      2'd0: pair_bad = d == EAG_KIND_MEM || s == EAG_KIND_MEM;
      2'd1: pair_bad = d == EAG_KIND_NONE;
      2'd2: pair_bad = !(d == EAG_KIND_REG && s != EAG_KIND_NONE)
        && !(d == EAG_KIND_MEM && (s == EAG_KIND_REG
        || s == EAG_KIND_IMM));
      default: pair_bad = d != EAG_KIND_REG || t != EAG_KIND_IMM;
    endcase
  endfunction

  task automatic rnd();
    reg_sel = 3'($random(seed));
    reg_byte = 1'($random(seed));
    imm = $random(seed);
    base_en = 1'($random(seed));
    base_sel = 3'($random(seed));
    index_en = 1'($random(seed));
    index_sel = 3'($random(seed));
    scale_sel = 2'($random(seed));
    disp = $random(seed);
    disp_size = eag_disp_type'(2'($random(seed)));
    seg_base = $random(seed);
    src_kind = $random(seed) & 1 ? EAG_KIND_REG : EAG_KIND_IMM;
    op_count = 2'h2;
    dst_kind = EAG_KIND_MEM;
    third_kind = EAG_KIND_NONE;
    {d_bit, real_m, opfx, afx} = 4'($random(seed));
  endtask

  // Issue the held fields, wait for done, compare every result
  task automatic run_req();
    int n;
    logic a32, o32, ill, vi, slow, bz, mu;
    logic [31:0] e, dv, op;
    a32 = (d_bit & ~real_m) ^ afx;
    o32 = (d_bit & ~real_m) ^ opfx;
    vi = index_en && index_sel != EAG_SP_IDX;
    ill = (index_en && !vi) || (disp_size == EAG_DISP_16 && vi && a32)
      || pair_bad(op_count, dst_kind, src_kind, third_kind);
    slow = base_en && vi;
    mu = dst_kind == EAG_KIND_MEM || src_kind == EAG_KIND_MEM;
    case (disp_size)
      EAG_DISP_8: dv = {{24{disp[7]}}, disp[7:0]};
      EAG_DISP_16: dv = {{16{disp[15]}}, disp[15:0]};
      EAG_DISP_32: dv = disp;
      default: dv = 32'h0000_0000;
    endcase
    e = (base_en ? regs[base_sel] : 0) + (vi ? regs[index_sel] << scale_sel
      : 0) + dv;
    if (!a32) e = e & EAG_MASK16;
    op = src_kind == EAG_KIND_REG ? regs[reg_sel]
      : src_kind == EAG_KIND_IMM ? imm : 32'h0000_0000;
    op = op & (reg_byte ? EAG_MASK8 : o32 ? 32'hffff_ffff : EAG_MASK16);
    reqs++;
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    bz = o_busy;
    n = 1;
    while (o_done !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    if (o_done !== 1'b1) begin
      chk(1'b0, "no done");
      wrap_up();
    end else begin
      chk(n == (slow ? 2 : 1) && bz === slow, "latency");
      chk(o_offset === e, "offset");
      chk(o_linear_addr === seg_base + e, "linear");
      chk(o_addr32 === a32 && o_op32 === o32, "size");
      chk(o_illegal === ill, "illegal flag");
      chk(o_operand === op, "operand");
      chk(o_mem_used === mu, "mem flag");
      @(negedge mclk);
      chk(o_done === 1'b0 && last_addr === seg_base + e, "pulse");
    end
  endtask

  // Main sequence
  initial begin
    {arst_n, wr_en, req_valid, wr_idx, wr_data} = '0;
    rnd();
    repeat (4) @(negedge mclk);
    arst_n = 1'b1;
    for (int i = 0; i < 8; i++) wr(3'(i), $random(seed));
    for (int k = 0; k < 16; k++) begin
      rnd();
      disp_size = eag_disp_type'(2'(k >> 2));
      {index_en, base_en} = 2'(k);
      run_req();
    end
    $display("mode mix done");
    for (int k = 0; k < 5; k++) begin
      rnd();
      index_en = 1'b1;
      scale_sel = 2'(k);
      index_sel = k == 4 ? EAG_SP_IDX : 3'h1;
      run_req();
    end
    $display("scale and stack index done");
    for (int k = 0; k < 16; k++) begin
      rnd();
      {d_bit, real_m, opfx, afx} = 4'(k);
      wr(3'h5, 32'hffff_fff8);
      {base_en, base_sel, index_en} = {1'b1, 3'h5, 1'b0};
      disp_size = EAG_DISP_8;
      disp = 32'h0000_0010;
      run_req();
    end
    $display("size and wrap done");
    // Every count, destination, source and third kind
    for (int k = 0; k < 256; k++) begin
      rnd();
      op_count = 2'(k >> 6);
      third_kind = eag_kind_type'(2'(k >> 4));
      dst_kind = eag_kind_type'(2'(k >> 2));
      src_kind = eag_kind_type'(2'(k));
      run_req();
    end
    $display("operand pairing done");
    for (int k = 0; k < 200; k++) begin
      rnd();
      if (k % 7 == 0) wr(3'($random(seed)), $random(seed));
      run_req();
    end
    $display("random requests done");
    chk(seen == 16'(reqs), "done count");
    // Mid-run reset clears results, register file and the model
    arst_n = 1'b0;
    @(negedge mclk);
    chk({o_busy, o_done, o_illegal, o_op32, o_addr32, o_mem_used,
      o_offset, o_linear_addr, o_operand, seen} === '0, "reset");
    arst_n = 1'b1;
    reqs = 0;
    for (int i = 0; i < 8; i++) regs[i] = 32'h0000_0000;
    for (int k = 0; k < 8; k++) begin
      rnd();
      run_req();
    end
    $display("mid-run reset done");
    chk(seen == 16'(reqs), "done count after reset");
    wrap_up();
  end
endmodule
